// file: pkg/dcache_defs.svh
// Purpose: shared constants of the data cache line state controller
// Assumes: included by bare name, guarded against double inclusion
// Notes: definitions only
`ifndef DCACHE_DEFS_SVH
`define DCACHE_DEFS_SVH
// ---------------------------------------------------------------------
// geometry
// ---------------------------------------------------------------------
`define WAYS 4
`define WORDS 4
`define ADDR_W 32
`define DATA_W 32
`define BE_W 4
`define BYTE_W 8
`define TAG_W 28
`define TAG_LO 4
`define WSEL_LO 2
`define WSEL_HI 3
`define LINE_OFS 4'h0
`define BE_ALL 4'hf
`define SET_BITS_DEF 2
`define SET_BITS_MAX 8
// ---------------------------------------------------------------------
// codes and counts
// ---------------------------------------------------------------------
`define MODE_W 2
`define MODE_CB 2'h1
`define SC_W 2
`define SC_LEAVE 2'h1
`define SC_INVAL 2'h2
`define FIRST_BEAT 2'h0
`define LAST_BEAT 2'h3
`define LFSR_SEED 8'ha5
`define LFSR_TAPS 8'hb8
`endif

// file: pkg/dcache_pkg.sv
// Purpose: types of the data cache line state controller
// Assumes: constants come from dcache_defs.svh
// Notes: none
`default_nettype none
`include "dcache_defs.svh"
package dcache_pkg;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef logic [`DATA_W-1:0] word_t;
	typedef logic [`BE_W-1:0] be_t;
	typedef logic [`MODE_W-1:0] pmode_t;
	typedef logic [`SC_W-1:0] sc_t;
	typedef logic [1:0] way_t;
	typedef logic [1:0] beat_t;
	// controller sequence
	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_FILL = 2'h1,
		S_PUSHBUF = 2'h2,
		S_WTHRU = 2'h3
	} fsm_t;
endpackage
`default_nettype wire

// file: pkg/victim_if.sv
// Purpose: link between the line controller and the victim picker
// Assumes: one driver per signal, set by the modports
// Notes: way is combinational from vld and picker state
`timescale 1ns/100ps
`default_nettype none
`include "dcache_defs.svh"
interface victim_if;
	logic [`WAYS-1:0] vld;
	logic step;
	dcache_pkg::way_t way;
	modport pick (input vld, input step, output way);
	modport user (output vld, output step, input way);
endinterface
`default_nettype wire

// file: rtl/victim_pick.sv
// Purpose: chooses the way to replace in the addressed set
// Assumes: step is high for one cycle per allocation
// Notes: free ways first, pseudo-random otherwise
`timescale 1ns/100ps
`default_nettype none
`include "dcache_defs.svh"
module victim_pick (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// controller side
	victim_if.pick vif
);
	import dcache_pkg::*;

	typedef struct packed {
		logic [7:0] lfsr;
	} vst_t;

	vst_t st_r;
	vst_t st_nxt;

	// lowest free way, else the random draw
	function automatic way_t pick(input logic [`WAYS-1:0] v, input way_t rnd);
		pick = rnd;
		for (int i = `WAYS - 1; i >= 0; i--) begin
			if (!v[i]) begin
				pick = way_t'(i);
			end
		end
	endfunction

	// ---------------------------------------------------------------
	// selection
	// ---------------------------------------------------------------
	assign vif.way = pick(vif.vld, st_r.lfsr[1:0]);

	// lfsr advances on each allocation
	always_comb begin
		st_nxt = st_r;
		if (vif.step) begin
			st_nxt.lfsr = {st_r.lfsr[6:0], ^(st_r.lfsr & `LFSR_TAPS)};
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= `LFSR_SEED;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb_v @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	a_victim_prefers_free: assert property (
		(vif.vld != {`WAYS{1'b1}}) |-> !vif.vld[vif.way])
		else $error("victim is a used way while a free way exists");
	a_victim_random_draw: assert property (
		(&vif.vld && vif.step) |-> (vif.way == st_r.lfsr[1:0]) ##1 (st_r.lfsr != $past(st_r.lfsr)))
		else $error("full set victim not taken from the random draw");
endmodule
`default_nettype wire

// file: rtl/dcache_line_ctrl.sv
// Purpose: per-line state control of a four-way data cache
// Assumes: all inputs come from logic on mclk_in; 20 MHz clock
// Notes: states are invalid, valid (no dirty flag) and dirty
//
`timescale 1ns/100ps
`default_nettype none
`include "dcache_defs.svh"
module dcache_line_ctrl #(
	parameter int SET_BITS = `SET_BITS_DEF
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// processor access
	input wire logic cpu_req_in,
	input wire logic cpu_we_in,
	input wire dcache_pkg::addr_t cpu_addr_in,
	input wire dcache_pkg::word_t cpu_wdata_in,
	input wire dcache_pkg::be_t cpu_be_in,
	input wire dcache_pkg::pmode_t page_cache_mode_field_in,
	output logic cpu_ready_out,
	output logic cpu_ack_out,
	output dcache_pkg::word_t cpu_rdata_out,
	// line maintenance
	input wire logic cache_invalidate_op_in,
	input wire logic cache_push_op_in,
	input wire dcache_pkg::addr_t op_addr_in,
	output logic op_ready_out,
	output logic op_done_out,
	// snooped alternate master access
	input wire logic snp_valid_in,
	input wire logic snp_we_in,
	input wire logic snp_line_in,
	input wire dcache_pkg::sc_t snoop_control_code_in,
	input wire dcache_pkg::addr_t snp_addr_in,
	input wire dcache_pkg::word_t snp_wdata_in,
	input wire dcache_pkg::be_t snp_be_in,
	output logic snp_ready_out,
	output logic snp_done_out,
	output logic memory_inhibit_out,
	output dcache_pkg::word_t snp_rdata_out,
	// memory side
	output logic mem_req_out,
	output logic mem_we_out,
	output logic mem_line_out,
	output dcache_pkg::addr_t mem_addr_out,
	output dcache_pkg::word_t mem_wdata_out,
	output dcache_pkg::be_t mem_be_out,
	input wire dcache_pkg::word_t mem_rdata_in,
	input wire logic mem_ack_in
);
	import dcache_pkg::*;

	localparam int SETS = 1 << SET_BITS;

	if (SET_BITS < 1 || SET_BITS > `SET_BITS_MAX) begin : g_bad_sets
		$error("SET_BITS out of range");
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		fsm_t st;
		logic [SETS-1:0][`WAYS-1:0] vld;
		logic [SETS-1:0][`WAYS-1:0][`WORDS-1:0] drt;
		logic [SETS-1:0][`WAYS-1:0][`TAG_W-1:0] tag;
		logic [SETS-1:0][`WAYS-1:0][`WORDS-1:0][`DATA_W-1:0] dat;
		logic pb_vld;
		logic [`TAG_W-1:0] pb_tag;
		logic [`WORDS-1:0][`DATA_W-1:0] pb_dat;
		addr_t rq_addr;
		logic rq_we;
		logic rq_op;
		word_t rq_wdata;
		be_t rq_be;
		way_t rq_way;
		beat_t cnt;
		logic cpu_ack;
		word_t cpu_rdata;
		logic op_done;
		logic snp_done;
		logic inh;
		word_t snp_rdata;
		logic mem_req;
		logic mem_we;
		logic mem_line;
		addr_t mem_addr;
		word_t mem_wdata;
		be_t mem_be;
	} st_t;

	st_t st_r;
	st_t st_nxt;

	logic [SET_BITS-1:0] cpu_set;
	logic [SET_BITS-1:0] op_set;
	logic [SET_BITS-1:0] snp_set;
	logic [SET_BITS-1:0] fset;
	beat_t cpu_word;
	beat_t snp_word;
	beat_t fword;
	beat_t nbeat;
	logic [`WAYS-1:0] cpu_hit;
	logic [`WAYS-1:0] op_hit;
	logic [`WAYS-1:0] snp_hit;
	logic [`WAYS-1:0] op_dirty;
	logic [`WAYS-1:0] snp_dirty;
	way_t hw;
	way_t ow;
	way_t sw;
	logic cpu_cb;
	logic cpu_take;
	logic op_take;
	logic snp_take;
	logic snp_act;
	logic snp_sink;
	logic pb_hit;
	logic alloc;
	word_t fill_word;

	victim_if vif ();

	victim_pick u_victim (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.vif(vif)
	);

	// byte-lane merge of a write into a longword
	function automatic word_t merge(input word_t old, input word_t nw, input be_t be);
		merge = old;
		for (int b = 0; b < `BE_W; b++) begin
			if (be[b]) begin
				merge[b*`BYTE_W +: `BYTE_W] = nw[b*`BYTE_W +: `BYTE_W];
			end
		end
	endfunction

	// one-hot hit vector to way number
	function automatic way_t enc(input logic [`WAYS-1:0] h);
		enc = '0;
		for (int i = 0; i < `WAYS; i++) begin
			if (h[i]) begin
				enc = way_t'(i);
			end
		end
	endfunction

	// ---------------------------------------------------------------
	// lookup
	// ---------------------------------------------------------------
	assign cpu_set = cpu_addr_in[`TAG_LO +: SET_BITS];
	assign op_set = op_addr_in[`TAG_LO +: SET_BITS];
	assign snp_set = snp_addr_in[`TAG_LO +: SET_BITS];
	assign fset = st_r.rq_addr[`TAG_LO +: SET_BITS];
	assign cpu_word = cpu_addr_in[`WSEL_HI:`WSEL_LO];
	assign snp_word = snp_addr_in[`WSEL_HI:`WSEL_LO];
	assign fword = st_r.rq_addr[`WSEL_HI:`WSEL_LO];
	assign nbeat = st_r.cnt + 2'h1;

	// tag compare and dirty summary per way
	for (genvar w = 0; w < `WAYS; w++) begin : g_way
		assign cpu_hit[w] = st_r.vld[cpu_set][w]
			&& st_r.tag[cpu_set][w] == cpu_addr_in[`ADDR_W-1:`TAG_LO];
		assign op_hit[w] = st_r.vld[op_set][w]
			&& st_r.tag[op_set][w] == op_addr_in[`ADDR_W-1:`TAG_LO];
		assign snp_hit[w] = st_r.vld[snp_set][w]
			&& st_r.tag[snp_set][w] == snp_addr_in[`ADDR_W-1:`TAG_LO];
		assign op_dirty[w] = |st_r.drt[op_set][w];
		assign snp_dirty[w] = |st_r.drt[snp_set][w];
	end

	assign hw = enc(cpu_hit);
	assign ow = enc(op_hit);
	assign sw = enc(snp_hit);
	assign cpu_cb = page_cache_mode_field_in == `MODE_CB;
	assign pb_hit = st_r.pb_vld && st_r.pb_tag == snp_addr_in[`ADDR_W-1:`TAG_LO];
	assign snp_sink = snp_dirty[sw] && snoop_control_code_in == `SC_LEAVE && !snp_line_in;
	assign fill_word = (fword == st_r.cnt) ? mem_rdata_in : st_r.dat[fset][st_r.rq_way][fword];

	// ---------------------------------------------------------------
	// acceptance, snoop first, then maintenance, then processor
	// ---------------------------------------------------------------
	assign snp_ready_out = st_r.st == S_IDLE || (st_r.st == S_PUSHBUF && !st_r.mem_req);
	assign op_ready_out = st_r.st == S_IDLE && !snp_valid_in;
	assign cpu_ready_out = op_ready_out && !cache_invalidate_op_in && !cache_push_op_in;
	assign snp_take = snp_valid_in && snp_ready_out;
	assign snp_act = snp_take && (snoop_control_code_in == `SC_LEAVE
		|| snoop_control_code_in == `SC_INVAL);
	assign op_take = op_ready_out && (cache_invalidate_op_in || cache_push_op_in);
	assign cpu_take = cpu_ready_out && cpu_req_in;
	assign alloc = cpu_take && !(|cpu_hit) && !(cpu_we_in && !cpu_cb);
	assign vif.vld = st_r.vld[cpu_set];
	assign vif.step = alloc;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.cpu_ack = 1'b0;
		st_nxt.op_done = 1'b0;
		st_nxt.snp_done = snp_take;
		st_nxt.inh = 1'b0;
		case (st_r.st)
		S_IDLE: begin
			if (op_take) begin
				if (|op_hit && cache_push_op_in && op_dirty[ow]) begin
					// dirty line moves to the buffer and is written back
					st_nxt.pb_vld = 1'b1;
					st_nxt.pb_tag = op_addr_in[`ADDR_W-1:`TAG_LO];
					st_nxt.pb_dat = st_r.dat[op_set][ow];
					st_nxt.rq_op = 1'b1;
					st_nxt.st = S_PUSHBUF;
				end else begin
					st_nxt.op_done = 1'b1;
				end
				if (|op_hit) begin
					st_nxt.vld[op_set][ow] = 1'b0;
					st_nxt.drt[op_set][ow] = '0;
				end
			end else if (cpu_take) begin
				if (cpu_we_in && !cpu_cb) begin
					// write-through: memory always, cache only on a hit
					if (|cpu_hit) begin
						st_nxt.dat[cpu_set][hw][cpu_word] = merge(
							st_r.dat[cpu_set][hw][cpu_word], cpu_wdata_in, cpu_be_in);
					end
					st_nxt.mem_req = 1'b1;
					st_nxt.mem_we = 1'b1;
					st_nxt.mem_line = 1'b0;
					st_nxt.mem_addr = cpu_addr_in;
					st_nxt.mem_wdata = cpu_wdata_in;
					st_nxt.mem_be = cpu_be_in;
					st_nxt.st = S_WTHRU;
				end else if (|cpu_hit) begin
					st_nxt.cpu_ack = 1'b1;
					if (cpu_we_in) begin
						st_nxt.dat[cpu_set][hw][cpu_word] = merge(
							st_r.dat[cpu_set][hw][cpu_word], cpu_wdata_in, cpu_be_in);
						st_nxt.drt[cpu_set][hw][cpu_word] = 1'b1;
					end else begin
						st_nxt.cpu_rdata = st_r.dat[cpu_set][hw][cpu_word];
					end
				end else begin
					// allocate: a dirty victim is parked for later write-back
					if (|st_r.drt[cpu_set][vif.way]) begin
						st_nxt.pb_vld = 1'b1;
						st_nxt.pb_tag = st_r.tag[cpu_set][vif.way];
						st_nxt.pb_dat = st_r.dat[cpu_set][vif.way];
					end
					st_nxt.vld[cpu_set][vif.way] = 1'b0;
					st_nxt.drt[cpu_set][vif.way] = '0;
					st_nxt.rq_addr = cpu_addr_in;
					st_nxt.rq_we = cpu_we_in;
					st_nxt.rq_wdata = cpu_wdata_in;
					st_nxt.rq_be = cpu_be_in;
					st_nxt.rq_way = vif.way;
					st_nxt.rq_op = 1'b0;
					st_nxt.cnt = `FIRST_BEAT;
					st_nxt.mem_req = 1'b1;
					st_nxt.mem_we = 1'b0;
					st_nxt.mem_line = 1'b1;
					st_nxt.mem_be = `BE_ALL;
					st_nxt.mem_addr = {cpu_addr_in[`ADDR_W-1:`TAG_LO], `LINE_OFS};
					st_nxt.st = S_FILL;
				end
			end
		end
		S_FILL: begin
			if (mem_ack_in) begin
				st_nxt.dat[fset][st_r.rq_way][st_r.cnt] = mem_rdata_in;
				st_nxt.cnt = nbeat;
				if (st_r.cnt == `LAST_BEAT) begin
					// install the line, merge a pending copyback write
					st_nxt.tag[fset][st_r.rq_way] = st_r.rq_addr[`ADDR_W-1:`TAG_LO];
					st_nxt.vld[fset][st_r.rq_way] = 1'b1;
					st_nxt.drt[fset][st_r.rq_way] = '0;
					if (st_r.rq_we) begin
						st_nxt.dat[fset][st_r.rq_way][fword] = merge(
							fill_word, st_r.rq_wdata, st_r.rq_be);
						st_nxt.drt[fset][st_r.rq_way][fword] = 1'b1;
					end
					st_nxt.cpu_ack = 1'b1;
					st_nxt.cpu_rdata = fill_word;
					st_nxt.mem_req = 1'b0;
					st_nxt.st = st_r.pb_vld ? S_PUSHBUF : S_IDLE;
				end
			end
		end
		S_PUSHBUF: begin
			if (!st_r.pb_vld || (st_r.mem_req && mem_ack_in && st_r.cnt == `LAST_BEAT)) begin
				st_nxt.pb_vld = 1'b0;
				st_nxt.mem_req = 1'b0;
				st_nxt.op_done = st_r.rq_op;
				st_nxt.rq_op = 1'b0;
				st_nxt.st = S_IDLE;
			end else if (!st_r.mem_req) begin
				// start the line write of the buffered data
				st_nxt.mem_req = 1'b1;
				st_nxt.mem_we = 1'b1;
				st_nxt.mem_line = 1'b1;
				st_nxt.mem_be = `BE_ALL;
				st_nxt.mem_addr = {st_r.pb_tag, `LINE_OFS};
				st_nxt.mem_wdata = st_r.pb_dat[`FIRST_BEAT];
				st_nxt.cnt = `FIRST_BEAT;
			end else if (mem_ack_in) begin
				st_nxt.cnt = nbeat;
				st_nxt.mem_wdata = st_r.pb_dat[nbeat];
			end
		end
		S_WTHRU: begin
			if (mem_ack_in) begin
				st_nxt.mem_req = 1'b0;
				st_nxt.cpu_ack = 1'b1;
				st_nxt.st = S_IDLE;
			end
		end
		default: begin
			st_nxt.st = S_IDLE;
		end
		endcase
		// snoop on the arrays, else on the push buffer
		if (snp_act) begin
			if (|snp_hit) begin
				if (!snp_we_in) begin
					if (snp_dirty[sw]) begin
						st_nxt.inh = 1'b1;
						st_nxt.snp_rdata = st_r.dat[snp_set][sw][snp_word];
					end
					if (snoop_control_code_in == `SC_INVAL) begin
						st_nxt.vld[snp_set][sw] = 1'b0;
						st_nxt.drt[snp_set][sw] = '0;
					end
				end else if (snp_sink) begin
					st_nxt.inh = 1'b1;
					st_nxt.dat[snp_set][sw][snp_word] = merge(
						st_r.dat[snp_set][sw][snp_word], snp_wdata_in, snp_be_in);
					st_nxt.drt[snp_set][sw][snp_word] = 1'b1;
				end else begin
					st_nxt.vld[snp_set][sw] = 1'b0;
					st_nxt.drt[snp_set][sw] = '0;
				end
			end else if (pb_hit) begin
				// the buffered line answers as a dirty line
				if (!snp_we_in) begin
					st_nxt.inh = 1'b1;
					st_nxt.snp_rdata = st_r.pb_dat[snp_word];
					if (snoop_control_code_in == `SC_INVAL) begin
						st_nxt.pb_vld = 1'b0;
					end
				end else if (snoop_control_code_in == `SC_LEAVE && !snp_line_in) begin
					st_nxt.inh = 1'b1;
					st_nxt.pb_dat[snp_word] = merge(
						st_r.pb_dat[snp_word], snp_wdata_in, snp_be_in);
				end else begin
					st_nxt.pb_vld = 1'b0;
				end
			end
		end
	end

	// register the whole state
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign cpu_ack_out = st_r.cpu_ack;
	assign cpu_rdata_out = st_r.cpu_rdata;
	assign op_done_out = st_r.op_done;
	assign snp_done_out = st_r.snp_done;
	assign memory_inhibit_out = st_r.inh;
	assign snp_rdata_out = st_r.snp_rdata;
	assign mem_req_out = st_r.mem_req;
	assign mem_we_out = st_r.mem_we;
	assign mem_line_out = st_r.mem_line;
	assign mem_addr_out = st_r.mem_addr;
	assign mem_wdata_out = st_r.mem_wdata;
	assign mem_be_out = st_r.mem_be;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb_m @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_fill_last;
		st_r.st == S_FILL && mem_ack_in && st_r.cnt == `LAST_BEAT;
	endsequence
	sequence s_cpu_miss;
		cpu_take && !(|cpu_hit);
	endsequence

	a_read_miss_fill: assert property (
		(s_cpu_miss and !cpu_we_in) |=> st_r.st == S_FILL && mem_line_out && !mem_we_out)
		else $error("read miss did not start a line fill");
	a_fill_finish: assert property (
		s_fill_last |=> cpu_ack_out && mem_req_out == 1'b0 && st_r.vld[fset][st_r.rq_way])
		else $error("line fill did not install and answer");
	a_read_hit_quiet: assert property (
		(cpu_take && !cpu_we_in && |cpu_hit) |=> cpu_ack_out && !mem_req_out && $stable(st_r.vld))
		else $error("read hit used the bus or changed state");
	a_cb_miss_alloc: assert property (
		(s_cpu_miss and cpu_we_in && cpu_cb) |=> st_r.st == S_FILL && st_r.rq_we)
		else $error("copyback write miss did not allocate");
	a_wt_miss_only_mem: assert property (
		(s_cpu_miss and cpu_we_in && !cpu_cb)
		|=> st_r.st == S_WTHRU && mem_we_out && $stable(st_r.vld) && $stable(st_r.drt))
		else $error("write-through miss touched line state");
	a_cb_hit_dirty: assert property (
		(cpu_take && cpu_we_in && cpu_cb && |cpu_hit)
		|=> cpu_ack_out && st_r.drt[$past(cpu_set)][$past(hw)][$past(cpu_word)])
		else $error("copyback write hit left the longword clean");
	a_wt_hit_mem: assert property (
		(cpu_take && cpu_we_in && !cpu_cb && |cpu_hit)
		|=> mem_req_out && mem_we_out && !mem_line_out && $stable(st_r.drt))
		else $error("write-through hit wrong memory write or flags");
	a_inval_no_mem: assert property (
		(op_take && !cache_push_op_in) |=> op_done_out && !mem_req_out && st_r.st == S_IDLE)
		else $error("invalidate wrote memory or did not finish");
	a_push_dirty: assert property (
		(op_take && cache_push_op_in && |op_hit && op_dirty[ow])
		|=> st_r.st == S_PUSHBUF && st_r.pb_vld && !st_r.vld[$past(op_set)][$past(ow)])
		else $error("push of a dirty line not written back");
	a_snp_clean_read: assert property (
		(snp_act && !snp_we_in && |snp_hit && !snp_dirty[sw]
		&& snoop_control_code_in == `SC_LEAVE) |=> !memory_inhibit_out && $stable(st_r.vld))
		else $error("clean line disturbed by snoop read");
	a_snp_dirty_read: assert property (
		(snp_act && !snp_we_in && |snp_hit && snp_dirty[sw]) |=> memory_inhibit_out && snp_done_out)
		else $error("dirty snoop read not inhibited");
	a_snp_sink: assert property (
		(snp_act && snp_we_in && |snp_hit && snp_sink)
		|=> memory_inhibit_out && st_r.drt[$past(snp_set)][$past(sw)][$past(snp_word)])
		else $error("snoop write not sunk into dirty line");
	a_snp_invalidate: assert property (
		(snp_act && |snp_hit && !(snp_we_in && snp_sink)
		&& (snoop_control_code_in == `SC_INVAL || snp_we_in))
		|=> !st_r.vld[$past(snp_set)][$past(sw)])
		else $error("snoop hit did not invalidate");
	a_snp_buffer: assert property (
		(snp_act && pb_hit && !(|snp_hit) && !snp_we_in) |=> memory_inhibit_out)
		else $error("push buffer not snooped");
endmodule
`default_nettype wire

// file: tb/mem_model.sv
// Purpose: memory partner answering line and longword bursts
// Assumes: requests come from dcache_line_ctrl
// Notes: outside an ack, data toggles each cycle between the last beat and its inverse
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// request side
	input wire logic slow_in,
	input wire logic mem_req_out,
	input wire logic mem_we_out,
	input wire dcache_pkg::addr_t mem_addr_out,
	// answer side
	output dcache_pkg::word_t mem_rdata_in,
	output logic mem_ack_in,
	output logic [7:0] fills_out,
	output logic [7:0] wbeats_out
);
	import dcache_pkg::*;
	beat_t beat_r;
	logic [1:0] wait_r;
	// one ack per beat, beat data taken from line base upwards
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_ack_in <= 1'b0;
			mem_rdata_in <= '0;
			beat_r <= '0;
			wait_r <= '0;
			fills_out <= '0;
			wbeats_out <= '0;
		end else begin
			mem_ack_in <= 1'b0;
			mem_rdata_in <= ~mem_rdata_in;
			if (!mem_req_out) begin
				beat_r <= '0;
				wait_r <= '0;
			end else if (!mem_ack_in && wait_r >= (slow_in ? 2'h2 : 2'h0)) begin
				mem_ack_in <= 1'b1;
				wait_r <= '0;
				beat_r <= beat_r + 2'h1;
				mem_rdata_in <= (mem_addr_out + {28'h0, beat_r, 2'h0}) ^ 32'h5a5a0000;
				if (mem_we_out)
					wbeats_out <= wbeats_out + 8'h1;
				else if (beat_r == 2'h0)
					fills_out <= fills_out + 8'h1;
			end else if (!mem_ack_in) begin
				wait_r <= wait_r + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/dcache_line_ctrl_tb.sv
// Purpose: self-checking bench of the line state controller
// Assumes: memory partner in mem_model
// Notes: snoop line size held low
`timescale 1ns/100ps
`default_nettype none
`include "dcache_defs.svh"
module dcache_line_ctrl_tb;
	import dcache_pkg::*;
	logic mclk_in = 1'b0, rst_n_in = 1'b0, slow_in = 1'b0, inh_out, inh;
	logic cpu_req_in = 1'b0, cpu_we_in = 1'b0, inv_in = 1'b0, push_in = 1'b0;
	logic snp_valid_in = 1'b0, snp_we_in = 1'b0, snp_line_in = 1'b0;
	logic cpu_ready_out, cpu_ack_out, op_ready_out, op_done_out, snp_ready_out, snp_done_out;
	logic mem_req_out, mem_we_out, mem_line_out, mem_ack_in;
	addr_t cpu_addr_in = '0, op_addr_in = '0, snp_addr_in = '0, mem_addr_out;
	word_t cpu_wdata_in = '0, snp_wdata_in = '0, cpu_rdata_out, snp_rdata_out, rd;
	word_t mem_wdata_out, mem_rdata_in, wd;
	be_t cpu_be_in = '0, snp_be_in = '0, mem_be_out;
	pmode_t pm_in = '0;
	sc_t sc_in = '0;
	logic [7:0] fills, wbeats, f0, w0;
	int errors = 0, n_compared = 0;
	wire [5:0] hs = {snp_done_out, op_done_out, cpu_ack_out, snp_ready_out, op_ready_out,
		cpu_ready_out};
	localparam addr_t A = 32'h1000, B = 32'h2010, C = 32'h3020, E = 32'h0030;
	localparam word_t D1 = 32'hc0de1234, D2 = 32'h0badf00d;
	// clock
	initial begin
		forever #25 mclk_in = ~mclk_in;
	end
	dcache_line_ctrl #(.SET_BITS(2)) i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.cpu_req_in(cpu_req_in), .cpu_we_in(cpu_we_in), .cpu_addr_in(cpu_addr_in),
		.cpu_wdata_in(cpu_wdata_in), .cpu_be_in(cpu_be_in), .page_cache_mode_field_in(pm_in),
		.cpu_ready_out(cpu_ready_out), .cpu_ack_out(cpu_ack_out), .cpu_rdata_out(cpu_rdata_out),
		.cache_invalidate_op_in(inv_in), .cache_push_op_in(push_in), .op_addr_in(op_addr_in),
		.op_ready_out(op_ready_out), .op_done_out(op_done_out), .snp_valid_in(snp_valid_in),
		.snp_we_in(snp_we_in), .snp_line_in(snp_line_in), .snoop_control_code_in(sc_in),
		.snp_addr_in(snp_addr_in), .snp_wdata_in(snp_wdata_in), .snp_be_in(snp_be_in),
		.snp_ready_out(snp_ready_out), .snp_done_out(snp_done_out), .memory_inhibit_out(inh_out),
		.snp_rdata_out(snp_rdata_out), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
		.mem_line_out(mem_line_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
		.mem_be_out(mem_be_out), .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in));
	mem_model i_mem (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .slow_in(slow_in),
		.mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
		.mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in), .fills_out(fills),
		.wbeats_out(wbeats));
	// last write beat taken by memory
	always @(posedge mclk_in) begin
		if (mem_ack_in && mem_we_out) begin
			wd <= mem_wdata_out;
		end
	end
	task automatic report_and_stop();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input word_t s, input word_t e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// bounded wait at falling edges for one handshake bit
	task automatic hi(input int k);
		int i;
		for (i = 0; i < 80 && hs[k] !== 1'b1; i++) @(negedge mclk_in);
		if (i == 80) begin
			errors++;
			report_and_stop();
		end
	endtask
	// taken at the edge after ready, then strobes dropped and answer awaited
	task automatic go(input int k);
		@(negedge mclk_in);
		hi(k);
		@(posedge mclk_in);
		cpu_req_in <= 1'b0;
		inv_in <= 1'b0;
		push_in <= 1'b0;
		snp_valid_in <= 1'b0;
		@(negedge mclk_in);
		hi(k + 3);
	endtask
	task automatic cpu(input logic we, input addr_t a, input word_t d, input pmode_t m);
		@(posedge mclk_in);
		f0 = fills;
		w0 = wbeats;
		cpu_req_in <= 1'b1;
		cpu_we_in <= we;
		cpu_addr_in <= a;
		cpu_wdata_in <= d;
		cpu_be_in <= `BE_ALL;
		pm_in <= m;
		go(0);
		rd = cpu_rdata_out;
	endtask
	task automatic snp(input logic we, input sc_t c, input addr_t a, input word_t d, input be_t b);
		@(posedge mclk_in);
		snp_valid_in <= 1'b1;
		snp_we_in <= we;
		sc_in <= c;
		snp_addr_in <= a;
		snp_wdata_in <= d;
		snp_be_in <= b;
		go(2);
		inh = inh_out;
		rd = snp_rdata_out;
	endtask
	task automatic op(input logic p, input addr_t a);
		@(posedge mclk_in);
		w0 = wbeats;
		push_in <= p;
		inv_in <= !p;
		op_addr_in <= a;
		go(1);
		chk("push beats", 32'(wbeats - w0), p ? 32'h4 : 32'h0);
		cpu(1'b0, a, '0, `MODE_CB);
		chk("refill", 32'(fills - f0), 32'h1);
	endtask
	task automatic t_read();
		cpu(1'b0, A + 4, '0, `MODE_CB);
		chk("miss data", rd, (A + 4) ^ 32'h5a5a0000);
		chk("miss fill", 32'(fills - f0), 32'h1);
		cpu(1'b0, A + 8, '0, `MODE_CB);
		chk("hit data", rd, (A + 8) ^ 32'h5a5a0000);
		snp(1'b0, `SC_LEAVE, A + 8, '0, `BE_ALL);
		chk("valid snoop inhibit", 32'(inh), 32'h0);
		cpu(1'b0, A + 8, '0, `MODE_CB);
		chk("hit no bus", 32'(fills - f0), 32'h0);
		$display("test read done");
	endtask
	task automatic t_dirty();
		cpu(1'b1, A + 4, D1, `MODE_CB);
		chk("cb hit bus", 32'(wbeats - w0), 32'h0);
		snp(1'b0, `SC_LEAVE, A + 4, '0, `BE_ALL);
		chk("dirty snoop inhibit", 32'(inh), 32'h1);
		chk("dirty snoop data", rd, D1);
		snp(1'b1, `SC_LEAVE, A + 4, 32'h77, 4'h1);
		chk("sink inhibit", 32'(inh), 32'h1);
		cpu(1'b0, A + 4, '0, `MODE_CB);
		chk("sunk data", rd, {D1[31:8], 8'h77});
		snp(1'b0, `SC_INVAL, A + 4, '0, `BE_ALL);
		chk("inval snoop data", rd, {D1[31:8], 8'h77});
		cpu(1'b0, A + 4, '0, `MODE_CB);
		chk("dropped line", 32'(fills - f0), 32'h1);
		$display("test dirty done");
	endtask
	task automatic t_wthru();
		slow_in <= 1'b1;
		cpu(1'b1, B, D2, 2'h0);
		chk("wt miss beats", 32'(wbeats - w0), 32'h1);
		chk("wt miss fill", 32'(fills - f0), 32'h0);
		chk("wt miss data", wd, D2);
		cpu(1'b0, B, '0, 2'h0);
		chk("no alloc", 32'(fills - f0), 32'h1);
		cpu(1'b1, B + 4, D1, 2'h0); // line is clean
		chk("wt hit beats", 32'(wbeats - w0), 32'h1);
		chk("wt hit data", wd, D1);
		snp(1'b0, `SC_LEAVE, B + 4, '0, `BE_ALL);
		chk("wt stays valid", 32'(inh), 32'h0);
		cpu(1'b0, B + 4, '0, 2'h0);
		chk("wt cache data", rd, D1);
		slow_in <= 1'b0;
		$display("test write-through done");
	endtask
	// full set of dirty lines, a fifth line forces a write-back
	task automatic t_full();
		for (int i = 0; i < 4; i++) begin
			cpu(1'b1, E + 32'(i) * 32'h1000, D1, `MODE_CB);
			chk("set fill", 32'(fills - f0), 32'h1);
		end
		for (int i = 0; i < 4; i++) begin
			cpu(1'b0, E + 32'(i) * 32'h1000, '0, `MODE_CB);
			chk("free way kept", rd, D1);
		end
		cpu(1'b0, E + 32'h4000, '0, `MODE_CB);
		chk("victim fill data", rd, (E + 32'h4000) ^ 32'h5a5a0000);
		cpu(1'b0, E + 32'h4000, '0, `MODE_CB);
		chk("victim beats", 32'(wbeats - w0), 32'h4);
		chk("victim last word", 32'(wd[11:0]), 32'h3c);
		snp(1'b1, `SC_INVAL, E + 32'h4000, '0, `BE_ALL);
		chk("snoop write inhibit", 32'(inh), 32'h0);
		cpu(1'b0, E + 32'h4000, '0, `MODE_CB);
		chk("snoop write drop", 32'(fills - f0), 32'h1);
		$display("test full set done");
	endtask
	task automatic t_ops();
		cpu(1'b1, B + 4, D1, `MODE_CB);
		op(1'b1, B);
		cpu(1'b1, B, D1, `MODE_CB);
		op(1'b0, B);
		cpu(1'b1, C, D2, `MODE_CB);
		chk("cb miss fill", 32'(fills - f0), 32'h1);
		snp(1'b0, `SC_LEAVE, C, '0, `BE_ALL);
		chk("cb miss dirty", rd, D2);
		$display("test ops done");
	endtask
	// reset, then scenarios in turn
	initial begin
		repeat (5) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		t_read();
		t_dirty();
		t_wthru();
		t_ops();
		t_full();
		report_and_stop();
	end
endmodule
`default_nettype wire
